// ==== logic/evs_cfg.svh ====
`ifndef EVS_CFG_SVH
`define EVS_CFG_SVH
// Notes on behaviour
// - Sixteen DMA channels 0 to 15 each get exactly one trigger line.
// - Channels 8 to 11 have no selector and follow only their own chaining completion input.
// - The selector registers sit at 0x01A0FF00, 0x01A0FF04 and 0x01A0FF0C, none for 8 to 11.
// - A channel fires whenever the event named by its programmed 6-bit code occurs.
// - Each register holds 6-bit fields at [5:0], [13:8], [21:16], [29:24], lowest channel lowest.
// - Bits 31:30, 23:22, 15:14 and 7:6 read as zero.
// - Writes to the reserved gaps change nothing.
// - Codes 1 to 3 are timers and memory interface, 4 to 7 pins 4-7, 0x0A pin 2, 0x0C to 0x0F serial.
// - Reset codes for channels 0 to 7 are 0 to 7 in channel order.
// - Reset codes for channels 12 to 15 are 0x0C to 0x0F.
// - Pin events 4 to 7 come from the external-interrupt capable pins 4 to 7.

`define EVS_ADDR_GROUP0  32'h01A0FF00
`define EVS_ADDR_GROUP1  32'h01A0FF04
`define EVS_ADDR_GROUP3  32'h01A0FF0C
`define EVS_RST_GROUP0   32'h03020100
`define EVS_RST_GROUP1   32'h07060504
`define EVS_RST_GROUP3   32'h0F0E0D0C
`define EVS_FIELD_MASK   32'h3F3F3F3F
`define EVS_CODE_NONE    6'h00
`define EVS_CODE_TIMER0  6'h01
`define EVS_CODE_TIMER1  6'h02
`define EVS_CODE_MEMIF   6'h03
`define EVS_CODE_PIN4    6'h04
`define EVS_CODE_PIN5    6'h05
`define EVS_CODE_PIN6    6'h06
`define EVS_CODE_PIN7    6'h07
`define EVS_CODE_PIN2    6'h0A
`define EVS_CODE_SER0_TX 6'h0C
`define EVS_CODE_SER0_RX 6'h0D
`define EVS_CODE_SER1_TX 6'h0E
`define EVS_CODE_SER1_RX 6'h0F
`endif

// ==== logic/evs_pkg.sv ====
package evs_pkg;
	typedef logic [5:0] evs_code_type;
	typedef enum logic [1:0] {
		EVS_IDLE   = 2'b01,
		EVS_ACCESS = 2'b10
	} evs_apb_type;
endpackage

// ==== logic/evs_mux.sv ====
`timescale 1ns/10ps
`include "evs_cfg.svh"
module evs_mux
	import evs_pkg::*;
(
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	input  wire evs_code_type code,
	input  wire logic [15:0]  events,
	output logic              trig_ff
);
	////////////////////////////////////////////////////////////////
	// Event index: bit n of events is the event of code n
	function automatic logic pick(input evs_code_type c, input logic [15:0] e);
		logic r;
		r = 1'b0;
		case (c)
			`EVS_CODE_TIMER0, `EVS_CODE_TIMER1, `EVS_CODE_MEMIF,
			`EVS_CODE_PIN4, `EVS_CODE_PIN5, `EVS_CODE_PIN6, `EVS_CODE_PIN7,
			`EVS_CODE_PIN2, `EVS_CODE_SER0_TX, `EVS_CODE_SER0_RX,
			`EVS_CODE_SER1_TX, `EVS_CODE_SER1_RX: r = e[c[3:0]];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	logic nxt_trig;
	always_comb begin
		nxt_trig = pick(code, events);
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			trig_ff <= 1'b0;
		end else begin
			trig_ff <= nxt_trig;
		end
	end
endmodule

// ==== logic/evs_top.sv ====
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`include "evs_cfg.svh"
module evs_top
	import evs_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timer0_event,
	input  wire logic        timer1_event,
	input  wire logic        memory_interface_event,
	input  wire logic        pin2_event,
	input  wire logic        pin4_event,
	input  wire logic        pin5_event,
	input  wire logic        pin6_event,
	input  wire logic        pin7_event,
	input  wire logic        serial0_transmit_event,
	input  wire logic        serial0_receive_event,
	input  wire logic        serial1_transmit_event,
	input  wire logic        serial1_receive_event,
	input  wire logic [3:0]  chain_completion,
	output logic [15:0]      channel_trigger
);
	////////////////////////////////////////////////////////////////
	// Registers
	logic [31:0]  group0_ff;
	logic [31:0]  group1_ff;
	logic [31:0]  group3_ff;
	logic [31:0]  prdata_ff;
	logic         pready_ff;
	logic         pslverr_ff;
	logic [3:0]   chain_ff;
	evs_apb_type  apb_ff;
	logic [15:0]  events;
	logic [15:0]  mux_trig;

	function automatic logic [1:0] decode(input logic [31:0] a);
		logic [1:0] r;
		r = 2'd3;
		case (a)
			`EVS_ADDR_GROUP0: r = 2'd0;
			`EVS_ADDR_GROUP1: r = 2'd1;
			`EVS_ADDR_GROUP3: r = 2'd2;
			default:          r = 2'd3;
		endcase
		return r;
	endfunction

	logic [1:0] sel;
	logic       setup;
	always_comb begin
		sel = decode(paddr);
		setup = psel && !penable && (apb_ff == EVS_IDLE);
	end

	////////////////////////////////////////////////////////////////
	// APB: no wait states, answer in access cycle after setup
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			apb_ff <= EVS_IDLE;
		end else begin
			case (apb_ff)
				EVS_IDLE:   apb_ff <= setup ? EVS_ACCESS : EVS_IDLE;
				EVS_ACCESS: apb_ff <= EVS_IDLE;
				default:    apb_ff <= EVS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end else begin
			pready_ff  <= setup;
			pslverr_ff <= setup && (sel == 2'd3);
			if (setup && !pwrite) begin
				case (sel)
					2'd0:    prdata_ff <= group0_ff & `EVS_FIELD_MASK;
					2'd1:    prdata_ff <= group1_ff & `EVS_FIELD_MASK;
					2'd2:    prdata_ff <= group3_ff & `EVS_FIELD_MASK;
					default: prdata_ff <= 32'h00000000;
				endcase
			end else begin
				prdata_ff <= 32'h00000000;
			end
		end
	end

	logic do_write;
	always_comb begin
		do_write = psel && penable && pwrite && pready_ff && (apb_ff == EVS_ACCESS);
	end

	////////////////////////////////////////////////////////////////
	// Selector registers
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			group0_ff <= `EVS_RST_GROUP0;
			group1_ff <= `EVS_RST_GROUP1;
			group3_ff <= `EVS_RST_GROUP3;
		end else if (do_write) begin
			case (sel)
				2'd0:    group0_ff <= pwdata & `EVS_FIELD_MASK;
				2'd1:    group1_ff <= pwdata & `EVS_FIELD_MASK;
				2'd2:    group3_ff <= pwdata & `EVS_FIELD_MASK;
				default: group0_ff <= group0_ff;
			endcase
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;

	////////////////////////////////////////////////////////////////
	// Event vector indexed by code, pins 4-7 from interrupt pins
	always_comb begin
		events = 16'h0000;
		events[1]  = timer0_event;
		events[2]  = timer1_event;
		events[3]  = memory_interface_event;
		events[4]  = pin4_event;
		events[5]  = pin5_event;
		events[6]  = pin6_event;
		events[7]  = pin7_event;
		events[10] = pin2_event;
		events[12] = serial0_transmit_event;
		events[13] = serial0_receive_event;
		events[14] = serial1_transmit_event;
		events[15] = serial1_receive_event;
	end

	logic [127:0] codes;
	always_comb begin
		codes = {group3_ff, 32'h00000000, group1_ff, group0_ff};
	end

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_ch
			if (gi >= 8 && gi <= 11) begin : g_chain
				assign mux_trig[gi] = chain_ff[gi-8];
			end else begin : g_sel
				evs_mux u_mux (
					.clk_sys (clk_sys),
					.rstn    (rstn),
					.code    (codes[(gi/4)*32 + (gi%4)*8 +: 6]),
					.events  (events),
					.trig_ff (mux_trig[gi])
				);
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			chain_ff <= 4'h0;
		end else begin
			chain_ff <= chain_completion;
		end
	end

	assign channel_trigger = mux_trig;

	////////////////////////////////////////////////////////////////
	// Checks
	a_gap_reads_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
		pready |-> ((prdata & ~`EVS_FIELD_MASK) == 32'h00000000))
		else $error("reserved bits read nonzero");
	a_chain_follows: assert property (@(posedge clk_sys) disable iff (!rstn)
		channel_trigger[11:8] == $past(chain_completion))
		else $error("chain channel not following completion");
	a_timer_route: assert property (@(posedge clk_sys) disable iff (!rstn)
		(group0_ff[13:8] == `EVS_CODE_TIMER0) |=> (channel_trigger[1] == $past(timer0_event)))
		else $error("channel 1 timer route wrong");
	a_serial_route: assert property (@(posedge clk_sys) disable iff (!rstn)
		(group3_ff[29:24] == `EVS_CODE_SER1_RX) |=>
		(channel_trigger[15] == $past(serial1_receive_event)))
		else $error("channel 15 serial route wrong");
	a_pin2_route: assert property (@(posedge clk_sys) disable iff (!rstn)
		(group1_ff[5:0] == `EVS_CODE_PIN2) |=> (channel_trigger[4] == $past(pin2_event)))
		else $error("channel 4 pin2 route wrong");
	a_reserved_silent: assert property (@(posedge clk_sys) disable iff (!rstn)
		(group0_ff[5:0] == `EVS_CODE_NONE || group0_ff[5:4] != 2'b00) |=> !channel_trigger[0])
		else $error("reserved code triggered channel 0");
	a_gap_write_held: assert property (@(posedge clk_sys) disable iff (!rstn)
		((group0_ff | group1_ff | group3_ff) & ~`EVS_FIELD_MASK) == 32'h00000000)
		else $error("reserved bits stored");
	a_write_lands: assert property (@(posedge clk_sys) disable iff (!rstn)
		(do_write && sel == 2'd1) |=> (group1_ff == ($past(pwdata) & `EVS_FIELD_MASK)))
		else $error("write not stored");
	a_ready_timing: assert property (@(posedge clk_sys) disable iff (!rstn)
		(psel && !penable && apb_ff == EVS_IDLE) |=> pready ##1 !pready)
		else $error("pready not one cycle after setup");

	////////////////////////////////////////////////////////////////
	// Register bus checks
	a_err_unmapped: assert property (@(posedge clk_sys) disable iff (!rstn)
		(setup && sel == 2'd3) |=>
		(pslverr == 1'b1))
		else $error("unmapped access without error");
	a_err_mapped: assert property (@(posedge clk_sys) disable iff (!rstn)
		(setup && sel != 2'd3) |=>
		(pslverr == 1'b0))
		else $error("mapped access flagged as error");
	a_err_with_ready: assert property (@(posedge clk_sys) disable iff (!rstn)
		pslverr |->
		(pready == 1'b1))
		else $error("error without ready");
	a_ready_after_setup: assert property (@(posedge clk_sys) disable iff (!rstn)
		pready |->
		$past(setup))
		else $error("ready without a setup cycle before it");
	a_idle_data_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
		(pready == 1'b0) |->
		(prdata == 32'h00000000))
		else $error("read data nonzero outside access");
	a_read_group0: assert property (@(posedge clk_sys) disable iff (!rstn)
		(setup && !pwrite && sel == 2'd0) |=>
		(prdata == ($past(group0_ff) & `EVS_FIELD_MASK)))
		else $error("group0 read data wrong");
	a_read_group1: assert property (@(posedge clk_sys) disable iff (!rstn)
		(setup && !pwrite && sel == 2'd1) |=>
		(prdata == ($past(group1_ff) & `EVS_FIELD_MASK)))
		else $error("group1 read data wrong");
	a_read_group3: assert property (@(posedge clk_sys) disable iff (!rstn)
		(setup && !pwrite && sel == 2'd2) |=>
		(prdata == ($past(group3_ff) & `EVS_FIELD_MASK)))
		else $error("group3 read data wrong");
	a_write_group0: assert property (@(posedge clk_sys) disable iff (!rstn)
		(do_write && sel == 2'd0) |=>
		(group0_ff == ($past(pwdata) & `EVS_FIELD_MASK)))
		else $error("group0 write not stored");
	a_write_group3: assert property (@(posedge clk_sys) disable iff (!rstn)
		(do_write && sel == 2'd2) |=>
		(group3_ff == ($past(pwdata) & `EVS_FIELD_MASK)))
		else $error("group3 write not stored");
	a_unmapped_dropped: assert property (@(posedge clk_sys) disable iff (!rstn)
		(do_write && sel == 2'd3) |=>
		($stable(group0_ff) && $stable(group1_ff) && $stable(group3_ff)))
		else $error("unmapped write changed a selector");
	a_hold_no_write: assert property (@(posedge clk_sys) disable iff (!rstn)
		(do_write == 1'b0) |=>
		($stable(group0_ff) && $stable(group1_ff) && $stable(group3_ff)))
		else $error("selector changed without a write");
	a_reset_group0: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(rstn) |->
		(group0_ff == `EVS_RST_GROUP0))
		else $error("group0 reset value wrong");
	a_reset_group1: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(rstn) |->
		(group1_ff == `EVS_RST_GROUP1))
		else $error("group1 reset value wrong");
	a_reset_group3: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(rstn) |->
		(group3_ff == `EVS_RST_GROUP3))
		else $error("group3 reset value wrong");

	////////////////////////////////////////////////////////////////
	// Routing checks
	a_timer1_route: assert property (@(posedge clk_sys) disable iff (!rstn)
		(group0_ff[21:16] == `EVS_CODE_TIMER1) |=>
		(channel_trigger[2] == $past(timer1_event)))
		else $error("channel 2 timer1 route wrong");
	a_memif_route: assert property (@(posedge clk_sys) disable iff (!rstn)
		(group0_ff[29:24] == `EVS_CODE_MEMIF) |=>
		(channel_trigger[3] == $past(memory_interface_event)))
		else $error("channel 3 memory interface route wrong");
	a_pin4_route: assert property (@(posedge clk_sys) disable iff (!rstn)
		(group1_ff[5:0] == `EVS_CODE_PIN4) |=>
		(channel_trigger[4] == $past(pin4_event)))
		else $error("channel 4 pin4 route wrong");
	a_pin7_route: assert property (@(posedge clk_sys) disable iff (!rstn)
		(group1_ff[29:24] == `EVS_CODE_PIN7) |=>
		(channel_trigger[7] == $past(pin7_event)))
		else $error("channel 7 pin7 route wrong");
	a_pin2_ch0: assert property (@(posedge clk_sys) disable iff (!rstn)
		(group0_ff[5:0] == `EVS_CODE_PIN2) |=>
		(channel_trigger[0] == $past(pin2_event)))
		else $error("channel 0 pin2 route wrong");
	a_ser0tx_route: assert property (@(posedge clk_sys) disable iff (!rstn)
		(group3_ff[5:0] == `EVS_CODE_SER0_TX) |=>
		(channel_trigger[12] == $past(serial0_transmit_event)))
		else $error("channel 12 serial route wrong");
	a_ser0rx_route: assert property (@(posedge clk_sys) disable iff (!rstn)
		(group3_ff[13:8] == `EVS_CODE_SER0_RX) |=>
		(channel_trigger[13] == $past(serial0_receive_event)))
		else $error("channel 13 serial route wrong");
	a_ser1tx_route: assert property (@(posedge clk_sys) disable iff (!rstn)
		(group3_ff[21:16] == `EVS_CODE_SER1_TX) |=>
		(channel_trigger[14] == $past(serial1_transmit_event)))
		else $error("channel 14 serial route wrong");
	a_any_to_ch15: assert property (@(posedge clk_sys) disable iff (!rstn)
		(group3_ff[29:24] == `EVS_CODE_TIMER0) |=>
		(channel_trigger[15] == $past(timer0_event)))
		else $error("channel 15 timer0 route wrong");
	a_reserved_ch12: assert property (@(posedge clk_sys) disable iff (!rstn)
		(group3_ff[5:0] inside {6'h00, 6'h08, 6'h09, 6'h0B} || group3_ff[5:4] != 2'b00) |=>
		(channel_trigger[12] == 1'b0))
		else $error("reserved code triggered channel 12");
endmodule

// ==== tb/evs_src.sv ====
`timescale 1ns/10ps
module evs_src (
	input  wire logic        clk_sys,
	input  wire logic        go,
	input  wire logic [4:0]  idx,
	output logic      [19:0] ev_ff
);
	// One-cycle pulse: bits 0-15 by event code, bits 16-19 chaining for channels 8-11
	always_ff @(posedge clk_sys) begin
		ev_ff <= go ? (20'h00001 << idx) : 20'h00000;
	end
endmodule

// ==== tb/evs_top_test.sv ====
`timescale 1ns/10ps
module evs_top_test;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        go = 1'b0;
	logic [4:0]  idx = 5'h00;
	logic [31:0] paddr = 32'h00000000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic [19:0] ev_ff;
	logic [15:0] channel_trigger;
	logic [15:0] exp_trig;
	logic [15:0] valid_codes = 16'hF4FE;
	logic [5:0]  code_of [16];
	int          bad_count = 0;
	int          checks_done = 0;
	int          cyc = 0;
	////////////////////////////////////////////////////////////////
	evs_top evs_top_inst (
		.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer0_event(ev_ff[1]), .timer1_event(ev_ff[2]), .memory_interface_event(ev_ff[3]),
		.pin2_event(ev_ff[10]), .pin4_event(ev_ff[4]), .pin5_event(ev_ff[5]),
		.pin6_event(ev_ff[6]), .pin7_event(ev_ff[7]), .serial0_transmit_event(ev_ff[12]),
		.serial0_receive_event(ev_ff[13]), .serial1_transmit_event(ev_ff[14]),
		.serial1_receive_event(ev_ff[15]), .chain_completion(ev_ff[19:16]),
		.channel_trigger(channel_trigger)
	);
	evs_src evs_src_inst (.clk_sys(clk_sys), .go(go), .idx(idx), .ev_ff(ev_ff));
	////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
		input logic err);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		chk(32'(pslverr), 32'(err));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic fire(input logic [4:0] i);
		@(posedge clk_sys);
		go <= 1'b1;
		idx <= i;
		@(posedge clk_sys);
		go <= 1'b0;
		@(posedge clk_sys);
		#1;
		for (int n = 0; n < 16; n++) begin
			if (n >= 8 && n <= 11) begin
				exp_trig[n] = (i == 5'(n + 8));
			end else begin
				exp_trig[n] = !i[4] && code_of[n] == 6'(i) && valid_codes[i[3:0]];
			end
		end
		chk(32'(channel_trigger), 32'(exp_trig));
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			give_verdict();
		end
	end
	initial begin
		code_of = '{0, 1, 2, 3, 4, 5, 6, 7, 0, 0, 0, 0, 12, 13, 14, 15};
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		apb(1'b0, 32'h01A0FF00, 32'h00000000, 1'b0);
		chk(rd, 32'h03020100);
		apb(1'b0, 32'h01A0FF04, 32'h00000000, 1'b0);
		chk(rd, 32'h07060504);
		apb(1'b0, 32'h01A0FF0C, 32'h00000000, 1'b0);
		chk(rd, 32'h0F0E0D0C);
		apb(1'b1, 32'h01A0FF08, 32'hFFFFFFFF, 1'b1);
		apb(1'b0, 32'h01A0FF08, 32'h00000000, 1'b1);
		chk(rd, 32'h00000000);
		apb(1'b1, 32'h01A0FF04, 32'hFFFFFFFF, 1'b0);
		apb(1'b0, 32'h01A0FF04, 32'h00000000, 1'b0);
		chk(rd, 32'h3F3F3F3F);
		apb(1'b1, 32'h01A0FF04, 32'hC0C0C0C0, 1'b0);
		apb(1'b0, 32'h01A0FF04, 32'h00000000, 1'b0);
		chk(rd, 32'h00000000);
		for (int n = 4; n < 8; n++) code_of[n] = 6'h00;
		$display("test registers done");
		for (int i = 0; i < 20; i++) fire(5'(i));
		$display("test default routing done");
		for (int c = 0; c < 17; c++) begin
			apb(1'b1, 32'h01A0FF00, {4{2'b00, 6'(c)}}, 1'b0);
			apb(1'b1, 32'h01A0FF04, {4{2'b00, 6'(c)}}, 1'b0);
			apb(1'b1, 32'h01A0FF0C, {4{2'b00, 6'(c)}}, 1'b0);
			for (int n = 0; n < 16; n++) code_of[n] = 6'(c);
			for (int i = 0; i < 20; i++) fire(5'(i));
		end
		$display("test programmed routing done");
		give_verdict();
	end
endmodule
